/* File: hw/dic_regs.vh */
`ifndef DIC_REGS_VH
`define DIC_REGS_VH
// Summary of operation
// [RULE_01] Two units: primary serves lines 0-7, secondary lines 8-15, each own ports.
// [RULE_02] Odd port holds line mask, bit n for line n, 1 blocks the request.
// [RULE_03] Even-port write with bits 4 and 3 zero is the priority/end-of-service command.
// [RULE_04] Code 001 clears highest in-service bit; code 011 clears the addressed one.
// [RULE_05] Low three bits give the level for specific end of service, set-priority, rotate.
// [RULE_06] Even-port write with bit 7 zero, bit 4 zero, bit 3 one is read-select.
// [RULE_07] Bit 5 sets special mask mode only when bit 6 is one.
// [RULE_08] Bit 2 selects polled mode instead of generating an interrupt.
// [RULE_09] Bit 0 picks pending or in-service read-back, only when bit 1 is one.
// [RULE_10] Pending read-back gives bit n set when line n request is pending.
// [RULE_11] In-service read-back gives bit n set when line n is being serviced.
// [RULE_12] Poll read gives bit 7 pending flag and bits 2-0 highest pending line.
// [RULE_13] Every write-only command and init word is captured for later read-back.
// [RULE_14] Shadows at 80h-83h/88h-8Bh, priority 85h/8Dh, read-select 86h/8Eh.
// [RULE_15] Automatic end of service clears the top in-service bit as acknowledge two ends.
// [RULE_16] Even-port write with bit 4 set is the first initialization word.

`define DIC_PRI_EVEN     8'h20
`define DIC_PRI_ODD      8'h21
`define DIC_SEC_EVEN     8'hA0
`define DIC_SEC_ODD      8'hA1

`define DIC_CFG_PRI_BASE 8'h80
`define DIC_CFG_SEC_BASE 8'h88
`define DIC_CFG_INIT_ONE 3'h0
`define DIC_CFG_ICW2     3'h1
`define DIC_CFG_ICW3     3'h2
`define DIC_CFG_ICW4     3'h3
`define DIC_CFG_PRIO_CMD 3'h5
`define DIC_CFG_RSEL_CMD 3'h6

`define DIC_BIT_INIT     4
`define DIC_BIT_RSEL     3
`define DIC_BIT_LEVEL    3
`define DIC_BIT_NO_ICW3  1
`define DIC_BIT_AEOI     1
`define DIC_BIT_ESMM     6
`define DIC_BIT_SMM      5
`define DIC_BIT_POLL     2
`define DIC_BIT_ERIS     1
`define DIC_BIT_RIS      0

`define DIC_OP_ROT_AEOI_CLR 3'h0
`define DIC_OP_NS_EOS       3'h1
`define DIC_OP_SP_EOS       3'h3
`define DIC_OP_ROT_AEOI_SET 3'h4
`define DIC_OP_ROT_NS_EOS   3'h5
`define DIC_OP_SET_PRIO     3'h6
`define DIC_OP_ROT_SP_EOS   3'h7

`define DIC_CASC_LINE    3'h2
`define DIC_RST_BYTE     8'h00
`define DIC_RST_LOW      3'h7
`endif

/* File: hw/dic_top.v */
`timescale 1ns/1ps
`include "dic_regs.vh"
module dic_top
(
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire [15:0] irq_i,
  input  wire        inta_i,
  input  wire [7:0]  io_addr_i,
  input  wire        io_wr_i,
  input  wire        io_rd_i,
  input  wire [7:0]  io_wdata_i,
  output reg  [7:0]  io_rdata_o,
  input  wire [7:0]  cfg_index_i,
  input  wire        cfg_rd_i,
  output reg  [7:0]  cfg_rdata_o,
  output wire        int_o,
  output reg  [7:0]  vec_o,
  output reg         vec_valid_o
);

  // Found flag in bit 3, line number below, scanning from just above low
  function [3:0] pick8;
    input [7:0] v;
    input [2:0] low;
    integer     k;
    reg   [2:0] idx;
    begin
      pick8 = 4'h0;
      for (k = 8; k >= 1; k = k - 1)
      begin
        idx = low + k[2:0];
        if (v[idx])
          pick8 = {1'b1, idx};
      end
    end
  endfunction

  // Three-stage capture; a level counts once stages two and three agree
  reg  [15:0] irq_s1_r;
  reg  [15:0] irq_s2_r;
  reg  [15:0] irq_s3_r;
  reg  [15:0] irq_st_r;
  reg  [2:0]  ack_s_r;
  reg         ack_st_r;
  reg         ack_phase_r;
  reg         casc_r;
  wire        ack_fall;
  wire [1:0]  int_w;
  wire [7:0]  pick_w;
  wire [15:0] vec_w;
  wire [15:0] rd_w;
  wire [1:0]  rd_hit_w;
  wire [15:0] cfg_w;
  wire [1:0]  cfg_hit_w;
  wire        casc_sel;

  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_s1_r <= 16'h0000;
      irq_s2_r <= 16'h0000;
      irq_s3_r <= 16'h0000;
      irq_st_r <= 16'h0000;
      ack_s_r  <= 3'h0;
      ack_st_r <= 1'b0;
    end
    else
    begin
      irq_s1_r <= irq_i;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
      irq_st_r <= (irq_s2_r & irq_s3_r) | (irq_st_r & (irq_s2_r | irq_s3_r));
      ack_s_r  <= {ack_s_r[1:0], inta_i};
      if (ack_s_r[1] == ack_s_r[2])
        ack_st_r <= ack_s_r[2];
    end
  end

  // Acknowledge acts on the trailing edge of each cycle
  assign ack_fall = ack_st_r & ~(ack_s_r[1] & ack_s_r[2]) & ~ack_s_r[1] & ~ack_s_r[2];
  assign casc_sel = int_w[0] & (pick_w[2:0] == `DIC_CASC_LINE);
  assign int_o    = int_w[0];

  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_phase_r <= 1'b0;
      casc_r      <= 1'b0;
      vec_o       <= `DIC_RST_BYTE;
      vec_valid_o <= 1'b0;
      io_rdata_o  <= `DIC_RST_BYTE;
      cfg_rdata_o <= `DIC_RST_BYTE;
    end
    else
    begin
      vec_valid_o <= 1'b0;
      if (ack_fall)
      begin
        ack_phase_r <= ~ack_phase_r;
        if (!ack_phase_r)
          casc_r <= casc_sel;
        else
        begin
          vec_o       <= casc_r ? vec_w[15:8] : vec_w[7:0];
          vec_valid_o <= 1'b1;
        end
      end
      if (io_rd_i)
        io_rdata_o <= rd_hit_w[1] ? rd_w[15:8] : (rd_hit_w[0] ? rd_w[7:0] : `DIC_RST_BYTE);
      if (cfg_rd_i)
        cfg_rdata_o <= cfg_hit_w[1] ? cfg_w[15:8] :
                       (cfg_hit_w[0] ? cfg_w[7:0] : `DIC_RST_BYTE);  // RULE_13
    end
  end

  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1)
    begin : unit
      // Unit 0 is the primary (lines 0-7), unit 1 the secondary (8-15)
      wire [7:0] even_a   = u ? `DIC_SEC_EVEN : `DIC_PRI_EVEN;  // RULE_01
      wire [7:0] odd_a    = u ? `DIC_SEC_ODD  : `DIC_PRI_ODD;
      wire [7:0] cfg_base = u ? `DIC_CFG_SEC_BASE : `DIC_CFG_PRI_BASE;
      wire [7:0] line_w   = u ? irq_st_r[15:8]
                              : {irq_st_r[7:3], int_w[1], irq_st_r[1:0]};
      wire       wr_even  = io_wr_i && (io_addr_i == even_a);
      wire       wr_odd   = io_wr_i && (io_addr_i == odd_a);
      wire       rd_even  = io_rd_i && (io_addr_i == even_a);
      wire       init_wr  = wr_even && io_wdata_i[`DIC_BIT_INIT];  // RULE_16
      wire       prio_wr  = wr_even && !io_wdata_i[`DIC_BIT_INIT]
                            && !io_wdata_i[`DIC_BIT_RSEL];  // RULE_03
      wire       rsel_wr  = wr_even && !io_wdata_i[7] && !io_wdata_i[`DIC_BIT_INIT]
                            && io_wdata_i[`DIC_BIT_RSEL];  // RULE_06
      wire [2:0] op       = io_wdata_i[7:5];
      wire [2:0] lvl      = io_wdata_i[2:0];  // RULE_05

      reg  [7:0] init_one_r;
      reg  [7:0] icw2_r;
      reg  [7:0] icw3_r;
      reg  [7:0] icw4_r;
      reg  [7:0] prio_cmd_r;
      reg  [7:0] rsel_cmd_r;
      reg  [1:0] init_st_r;
      reg  [7:0] imr_r;
      reg  [7:0] irr_r;
      reg  [7:0] isr_r;
      reg  [7:0] line_prev_r;
      reg  [2:0] low_r;
      reg  [2:0] ack_idx_r;
      reg        smm_r;
      reg        poll_r;
      reg        ris_r;
      reg        rot_aeoi_r;
      reg  [7:0] isr_nxt;
      reg  [7:0] irr_clr;
      reg  [2:0] low_nxt;

      wire       level_m  = init_one_r[`DIC_BIT_LEVEL];
      wire [7:0] req_w    = irr_r & ~imr_r;  // RULE_02
      // Special mask lets masked in-service lines stop blocking lower ones
      wire [7:0] isr_eff  = smm_r ? (isr_r & ~imr_r) : isr_r;
      wire [3:0] p_pend   = pick8(req_w, low_r);
      wire [3:0] p_serv   = pick8(isr_eff, low_r);
      wire [3:0] p_top_sv = pick8(isr_r, low_r);
      wire [2:0] rank_p   = p_pend[2:0] + ~low_r;
      wire [2:0] rank_s   = p_serv[2:0] + ~low_r;
      wire       pend_ok  = p_pend[3] && (!p_serv[3] || (rank_p < rank_s));
      wire       ack1     = ack_fall && !ack_phase_r && (u ? casc_sel : int_w[0]);
      wire       ack2     = ack_fall && ack_phase_r && (u ? casc_r : 1'b1);
      wire       poll_ack = rd_even && poll_r && pend_ok;
      wire       aeoi     = ack2 && icw4_r[`DIC_BIT_AEOI];
      wire [2:0] cfg_off  = cfg_index_i[2:0];
      wire       cfg_in   = (cfg_index_i[7:3] == cfg_base[7:3]);

      assign int_w[u]             = pend_ok && !poll_r;  // RULE_08
      assign pick_w[u*4 +: 4]     = {1'b0, p_pend[2:0]};
      assign vec_w[u*8 +: 8]      = {icw2_r[7:3], ack_idx_r};
      assign rd_hit_w[u]          = (io_addr_i == even_a) || (io_addr_i == odd_a);
      assign rd_w[u*8 +: 8]       = (io_addr_i == odd_a) ? imr_r :
                                    poll_r ? {pend_ok, 4'h0, p_pend[2:0]} :  // RULE_12
                                    ris_r ? isr_r : irr_r;  // RULE_10 RULE_11
      assign cfg_hit_w[u]         = cfg_in;
      assign cfg_w[u*8 +: 8]      = (cfg_off == `DIC_CFG_INIT_ONE) ? init_one_r :  // RULE_14
                                    (cfg_off == `DIC_CFG_ICW2) ? icw2_r :
                                    (cfg_off == `DIC_CFG_ICW3) ? icw3_r :
                                    (cfg_off == `DIC_CFG_ICW4) ? icw4_r :
                                    (cfg_off == `DIC_CFG_PRIO_CMD) ? prio_cmd_r :
                                    (cfg_off == `DIC_CFG_RSEL_CMD) ? rsel_cmd_r : `DIC_RST_BYTE;

      // End-of-service, rotation and acknowledge effects on in-service and priority
      always @*
      begin
        isr_nxt = isr_r;
        irr_clr = 8'h00;
        low_nxt = low_r;
        if (prio_wr && init_st_r == 2'h0)
        begin
          case (op)
            `DIC_OP_NS_EOS:
              if (p_top_sv[3])
                isr_nxt[p_top_sv[2:0]] = 1'b0;  // RULE_04
            `DIC_OP_ROT_NS_EOS:
              if (p_top_sv[3])
              begin
                isr_nxt[p_top_sv[2:0]] = 1'b0;
                low_nxt                = p_top_sv[2:0];
              end
            `DIC_OP_SP_EOS:
              isr_nxt[lvl] = 1'b0;  // RULE_04
            `DIC_OP_ROT_SP_EOS:
            begin
              isr_nxt[lvl] = 1'b0;
              low_nxt      = lvl;
            end
            `DIC_OP_SET_PRIO:
              low_nxt = lvl;
            default:
              low_nxt = low_r;
          endcase
        end
        if (aeoi && p_top_sv[3])
        begin
          isr_nxt[p_top_sv[2:0]] = 1'b0;  // RULE_15
          if (rot_aeoi_r)
            low_nxt = p_top_sv[2:0];
        end
        // Setting an in-service bit wins over a clear in the same cycle
        if (ack1 || poll_ack)
        begin
          isr_nxt[p_pend[2:0]] = 1'b1;
          irr_clr[p_pend[2:0]] = 1'b1;
        end
      end

      always @(posedge clk_sys_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          init_one_r  <= `DIC_RST_BYTE;
          icw2_r      <= `DIC_RST_BYTE;
          icw3_r      <= `DIC_RST_BYTE;
          icw4_r      <= `DIC_RST_BYTE;
          prio_cmd_r  <= `DIC_RST_BYTE;
          rsel_cmd_r  <= `DIC_RST_BYTE;
          init_st_r   <= 2'h0;
          imr_r       <= `DIC_RST_BYTE;
          irr_r       <= `DIC_RST_BYTE;
          isr_r       <= `DIC_RST_BYTE;
          line_prev_r <= `DIC_RST_BYTE;
          low_r       <= `DIC_RST_LOW;
          ack_idx_r   <= 3'h0;
          smm_r       <= 1'b0;
          poll_r      <= 1'b0;
          ris_r       <= 1'b0;
          rot_aeoi_r  <= 1'b0;
        end
        else
        begin
          line_prev_r <= line_w;
          // Edge mode: a new rising edge beats a clear in the same cycle
          if (level_m)
            irr_r <= line_w;
          else
            irr_r <= (irr_r & ~irr_clr) | (line_w & ~line_prev_r);
          isr_r <= isr_nxt;
          low_r <= low_nxt;
          if (ack1)
            ack_idx_r <= p_pend[2:0];
          if (init_wr)
          begin
            init_one_r <= io_wdata_i;  // RULE_13
            init_st_r <= 2'h1;
            imr_r     <= `DIC_RST_BYTE;
            isr_r     <= `DIC_RST_BYTE;
            low_r     <= `DIC_RST_LOW;
            smm_r     <= 1'b0;
            poll_r    <= 1'b0;
            ris_r     <= 1'b0;
          end
          else if (wr_odd && init_st_r == 2'h1)
          begin
            icw2_r    <= io_wdata_i;
            init_st_r <= init_one_r[`DIC_BIT_NO_ICW3] ? 2'h3 : 2'h2;
          end
          else if (wr_odd && init_st_r == 2'h2)
          begin
            icw3_r    <= io_wdata_i;
            init_st_r <= 2'h3;
          end
          else if (wr_odd && init_st_r == 2'h3)
          begin
            icw4_r    <= io_wdata_i;
            init_st_r <= 2'h0;
          end
          else if (wr_odd)
            imr_r <= io_wdata_i;  // RULE_02
          else if (prio_wr)
          begin
            prio_cmd_r <= io_wdata_i;  // RULE_13
            if (op == `DIC_OP_ROT_AEOI_SET)
              rot_aeoi_r <= 1'b1;
            else if (op == `DIC_OP_ROT_AEOI_CLR)
              rot_aeoi_r <= 1'b0;
          end
          else if (rsel_wr)
          begin
            rsel_cmd_r <= io_wdata_i;  // RULE_13
            if (io_wdata_i[`DIC_BIT_ESMM])
              smm_r <= io_wdata_i[`DIC_BIT_SMM];  // RULE_07
            poll_r <= io_wdata_i[`DIC_BIT_POLL];  // RULE_08
            if (io_wdata_i[`DIC_BIT_ERIS])
              ris_r <= io_wdata_i[`DIC_BIT_RIS];  // RULE_09
          end
        end
      end
    end
  endgenerate

endmodule

/* File: tb/dic_chk_sva.sv */
`timescale 1ns/1ps
module dic_chk (
  input logic       clk_sys_i,
  input logic       rst_n_i,
  input logic [7:0] io_addr_i,
  input logic       io_wr_i,
  input logic       io_rd_i,
  input logic [7:0] io_wdata_i,
  input logic [7:0] io_rdata_o,
  input logic [7:0] cfg_index_i,
  input logic       cfg_rd_i,
  input logic [7:0] cfg_rdata_o,
  input logic       int_o,
  input logic [7:0] vec_o,
  input logic       vec_valid_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_unmap;
    io_rd_i && !(io_addr_i inside {8'h20, 8'h21, 8'hA0, 8'hA1}) |=> io_rdata_o == 8'h00;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  property p_cfg_unk;
    cfg_rd_i && !(cfg_index_i inside {[8'h80:8'h83], 8'h85, 8'h86, [8'h88:8'h8B], 8'h8D, 8'h8E})
      |=> cfg_rdata_o == 8'h00;
  endproperty
  a_cfg_unk: assert property (p_cfg_unk) else $error("unknown index not zero");
  property p_rd_hold;
    !io_rd_i |=> $stable(io_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_vec_pulse;
    vec_valid_o |=> !vec_valid_o;
  endproperty
  a_vec_pulse: assert property (p_vec_pulse) else $error("vector valid too long");
  property p_vec_chg;
    $changed(vec_o) |-> vec_valid_o;
  endproperty
  a_vec_chg: assert property (p_vec_chg) else $error("vector changed silently");
  property p_mask_rb;
    io_wr_i && io_addr_i == 8'h21 ##1 !io_wr_i ##1 io_rd_i && io_addr_i == 8'h21
      |=> io_rdata_o == $past(io_wdata_i, 3);
  endproperty
  a_mask_rb: assert property (p_mask_rb) else $error("mask read-back wrong");
  property p_prio_sh;
    io_wr_i && io_addr_i == 8'h20 && io_wdata_i[4:3] == 2'b00 ##1 !io_wr_i
      ##1 cfg_rd_i && cfg_index_i == 8'h85 |=> cfg_rdata_o == $past(io_wdata_i, 3);
  endproperty
  a_prio_sh: assert property (p_prio_sh) else $error("priority shadow wrong");
  property p_rsel_sh;
    io_wr_i && io_addr_i == 8'h20 && io_wdata_i[7] == 1'b0 && io_wdata_i[4:3] == 2'b01
      ##1 !io_wr_i
      ##1 cfg_rd_i && cfg_index_i == 8'h86 |=> cfg_rdata_o == $past(io_wdata_i, 3);
  endproperty
  a_rsel_sh: assert property (p_rsel_sh) else $error("read-select shadow wrong");
  c_vec: cover property (vec_valid_o);
  c_int: cover property (int_o);
  c_even_rd: cover property (io_rd_i && io_addr_i == 8'h20);
endmodule
bind dic_top dic_chk dic_chk_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i),
  .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
  .cfg_index_i(cfg_index_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o), .int_o(int_o),
  .vec_o(vec_o), .vec_valid_o(vec_valid_o));

/* File: tb/dic_host.sv */
`timescale 1ns/1ps
module dic_host (
  input  logic        clk_i,
  output logic [15:0] irq_o,
  output logic        inta_o
);
  initial
  begin
    irq_o = 16'h0000;
    inta_o = 1'b0;
  end
  task automatic set_line(input int n, input logic v);
    @(negedge clk_i);
    irq_o[n] = v;
  endtask
  // Two pulses, 4 cycles each phase, above the 2-cycle minimum
  task automatic ack;
    repeat (2)
    begin
      @(negedge clk_i);
      inta_o = 1'b1;
      repeat (4) @(negedge clk_i);
      inta_o = 1'b0;
      repeat (4) @(negedge clk_i);
    end
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        clk_sys_i, rst_n_i, io_wr_i, io_rd_i, cfg_rd_i, int_o, vec_valid_o, inta_i;
  logic [15:0] irq_i;
  logic [7:0]  io_addr_i, io_wdata_i, io_rdata_o, cfg_index_i, cfg_rdata_o, vec_o, last_vec;
  int          miscompares = 0, total_checks = 0, cyc = 0;
  dic_top dic_top_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .irq_i(irq_i), .inta_i(inta_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .cfg_index_i(cfg_index_i), .cfg_rd_i(cfg_rd_i),
    .cfg_rdata_o(cfg_rdata_o), .int_o(int_o), .vec_o(vec_o), .vec_valid_o(vec_valid_o));
  dic_host dic_host_i (.clk_i(clk_sys_i), .irq_o(irq_i), .inta_o(inta_i));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Vector pulse lasts one cycle, so latch it here
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (vec_valid_o === 1'b1) last_vec <= vec_o;
    if (cyc == 3000)
    begin
      miscompares++;
      results;
    end
  end
  task results;
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge clk_sys_i);
    io_wr_i = 1'b0;
    // Idle cycle so back-to-back calls never toggle the strobe in one step
    @(negedge clk_sys_i);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge clk_sys_i);
    io_rd_i = 1'b0;
    chk("io read", io_rdata_o, exp);
    @(negedge clk_sys_i);
  endtask
  task cfg(input logic [7:0] i, input logic [7:0] exp);
    cfg_index_i = i;
    cfg_rd_i = 1'b1;
    @(negedge clk_sys_i);
    cfg_rd_i = 1'b0;
    chk("shadow", cfg_rdata_o, exp);
    @(negedge clk_sys_i);
  endtask
  task t_mask;
    wr(8'h21, 8'hA5);
    rd(8'h21, 8'hA5);
    wr(8'hA1, 8'h5A);
    rd(8'hA1, 8'h5A);
    rd(8'h55, 8'h00);
  endtask
  task t_init;
    wr(8'h20, 8'h11);
    wr(8'h21, 8'h08);
    wr(8'h21, 8'h04);
    wr(8'h21, 8'h00);
    cfg(8'h80, 8'h11);
    cfg(8'h81, 8'h08);
    cfg(8'h82, 8'h04);
    rd(8'h21, 8'h00);
    wr(8'hA0, 8'h13);
    wr(8'hA1, 8'h70);
    wr(8'hA1, 8'h02);
    cfg(8'h88, 8'h13);
    cfg(8'h89, 8'h70);
    cfg(8'h8B, 8'h02);
    rd(8'hA1, 8'h00);
  endtask
  task t_irq;
    dic_host_i.set_line(3, 1'b1);
    repeat (6) @(negedge clk_sys_i);
    wr(8'h20, 8'h0A);
    rd(8'h20, 8'h08);
    chk("int", {7'h00, int_o}, 8'h01);
    wr(8'h21, 8'h08);
    chk("int masked", {7'h00, int_o}, 8'h00);
    wr(8'h21, 8'h00);
    dic_host_i.ack;
    repeat (6) @(negedge clk_sys_i);
    chk("vector", last_vec, 8'h0B);
    wr(8'h20, 8'h0B);
    cfg(8'h86, 8'h0B);
    rd(8'h20, 8'h08);
    wr(8'h20, 8'h08);
    rd(8'h20, 8'h08);
    wr(8'h20, 8'h63);
    cfg(8'h85, 8'h63);
    rd(8'h20, 8'h00);
    cfg(8'h86, 8'h08);
    dic_host_i.set_line(3, 1'b0);
  endtask
  task t_nseoi;
    dic_host_i.set_line(5, 1'b1);
    repeat (6) @(negedge clk_sys_i);
    dic_host_i.ack;
    repeat (6) @(negedge clk_sys_i);
    rd(8'h20, 8'h20);
    wr(8'h20, 8'h20);
    rd(8'h20, 8'h00);
    dic_host_i.set_line(5, 1'b0);
  endtask
  task t_poll;
    dic_host_i.set_line(6, 1'b1);
    repeat (6) @(negedge clk_sys_i);
    wr(8'h20, 8'h0C);
    rd(8'h20, 8'h86);
    wr(8'h20, 8'h0B);
    rd(8'h20, 8'h40);
    wr(8'h20, 8'h20);
    rd(8'h20, 8'h00);
  endtask
  task t_casc;
    dic_host_i.set_line(10, 1'b1);
    repeat (8) @(negedge clk_sys_i);
    chk("int cascade", {7'h00, int_o}, 8'h01);
    dic_host_i.ack;
    repeat (6) @(negedge clk_sys_i);
    chk("vector cascade", last_vec, 8'h72);
    wr(8'hA0, 8'h0B);
    rd(8'hA0, 8'h00);
    rd(8'h20, 8'h04);
    dic_host_i.set_line(5, 1'b1);
    repeat (6) @(negedge clk_sys_i);
    chk("int nested", {7'h00, int_o}, 8'h00);
    wr(8'h21, 8'h04);
    wr(8'h20, 8'h68);
    chk("int special mask", {7'h00, int_o}, 8'h01);
    wr(8'h20, 8'h28);
    chk("int special mask kept", {7'h00, int_o}, 8'h01);
    wr(8'h20, 8'h48);
    chk("int special mask off", {7'h00, int_o}, 8'h00);
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    cfg_rd_i = 1'b0;
    io_addr_i = 8'h00;
    io_wdata_i = 8'h00;
    cfg_index_i = 8'h00;
    repeat (8) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    @(negedge clk_sys_i);
    t_mask;
    t_init;
    t_irq;
    t_nseoi;
    t_poll;
    t_casc;
    results;
  end
endmodule
